// >>> design/timer_regs.svh
`ifndef TIMER_REGS_SVH
`define TIMER_REGS_SVH

// Register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_MODE 8'h04
`define OFS_COUNT 8'h10
`define OFS_COMPARE_A 8'h14
`define OFS_COMPARE_B 8'h18
`define OFS_COMPARE_C 8'h1c
`define OFS_STATUS 8'h20

// Reset values
`define RST_MODE 32'h0000_0000
`define RST_VALUE16 16'h0000

// Mode register field positions (low bit of each field)
`define F_CLOCK_SELECT 0
`define F_CLOCK_INVERT 3
`define F_BURST 4
`define F_STOP_ON_C 6
`define F_DISABLE_ON_C 7
`define F_EVENT_EDGE 8
`define F_EVENT_SOURCE 10
`define F_EVENT_TRIG_EN 12
`define F_C_TRIG_EN 14
`define F_WAVE_MODE 15
`define F_A_ON_A 16
`define F_A_ON_C 18
`define F_A_ON_EVENT 20
`define F_A_ON_SOFT 22
`define F_B_ON_B 24
`define F_B_ON_C 26
`define F_B_ON_EVENT 28
`define F_B_ON_SOFT 30
`define MODE_WRITE_MASK 32'hffff_dfff

// Control register command bits
`define F_CMD_CLOCK_ENABLE 0
`define F_CMD_CLOCK_DISABLE 1
`define F_CMD_SOFT_TRIGGER 2

// Status register bits
`define F_ST_OVERFLOW 0
`define F_ST_A_MATCH 2
`define F_ST_B_MATCH 3
`define F_ST_C_MATCH 4
`define F_ST_EVENT 7
`define F_ST_CLOCK_ON 16
`define F_ST_MIRROR_A 17
`define F_ST_MIRROR_B 18

// Prescaler taps: bit i of a free counter toggles at master_clock / 2^(i+1)
`define DIV_TAP_2 0
`define DIV_TAP_8 2
`define DIV_TAP_32 4
`define DIV_TAP_128 6
`define DIV_TAP_1024 9
`define DIV_WIDTH 10

`endif

// >>> design/timer_pkg.sv
package timer_pkg;
    typedef enum logic [1:0] {
        act_none,
        act_set,
        act_clear,
        act_toggle
    } out_action_t;

    typedef enum logic [1:0] {
        edge_none,
        edge_rising,
        edge_falling,
        edge_both
    } event_edge_t;

    typedef enum logic [1:0] {
        src_pin_b,
        src_line_0,
        src_line_1,
        src_line_2
    } event_source_t;

    typedef enum logic [1:0] {
        resp_okay = 2'b00,
        resp_slverr = 2'b10
    } axi_resp_t;
endpackage

// >>> design/count_tick_gen.sv
`timescale 1ns/100ps
`include "timer_regs.svh"

module count_tick_gen #(
    parameter int DIV_W = `DIV_WIDTH
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [2:0] clock_select_in,
    input wire logic clock_invert_in,
    input wire logic [1:0] burst_in,
    input wire logic [2:0] ext_lines_in,
    output logic tick_out
);
    import timer_pkg::*;

    logic [DIV_W-1:0] divider;
    logic sel_level;
    logic gate_level;
    logic gated;
    logic gated_prev;

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            divider <= '0;
        end else if (clk_en_in) begin
            divider <= divider + 1'b1;
        end
    end

    always_comb begin
        case (clock_select_in)
            3'h0: sel_level = divider[`DIV_TAP_2];
            3'h1: sel_level = divider[`DIV_TAP_8];
            3'h2: sel_level = divider[`DIV_TAP_32];
            3'h3: sel_level = divider[`DIV_TAP_128];
            3'h4: sel_level = divider[`DIV_TAP_1024];
            3'h5: sel_level = ext_lines_in[0];
            3'h6: sel_level = ext_lines_in[1];
            default: sel_level = ext_lines_in[2];
        endcase
        case (burst_in)
            2'h0: gate_level = 1'b1;
            2'h1: gate_level = ext_lines_in[0];
            2'h2: gate_level = ext_lines_in[1];
            default: gate_level = ext_lines_in[2];
        endcase
        // Falling edge of the clock is a rising edge of its inverse
        gated = (sel_level ^ clock_invert_in) & gate_level;
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            gated_prev <= 1'b0;
            tick_out <= 1'b0;
        end else if (clk_en_in) begin
            gated_prev <= gated;
            tick_out <= gated & ~gated_prev;
        end
    end
endmodule

// >>> design/timer_waveform_channel.sv
// Summary of operation
// - Clock select: codes 0-4 master clock /2,/8,/32,/128,/1024; 5-7 external lines.
// - Clock invert 0 counts on rising edge, 1 on falling edge.
// - Burst field 0 ungated; 1-3 AND clock with external line 0-2.
// - Stop-on-C set stops the counter clock when count reaches C.
// - Disable-on-C set disables the counter clock when count reaches C.
// - Event edge: none, rising, falling or both edges of event signal.
// - Event source: pin B as input, or external line 0-2 with B driven.
// - Pin B as event source is an input and carries no waveform.
// - Event trigger enable makes an event reset counter and start clock.
// - C trigger enable makes a C match reset counter and start clock.
// - Mode bit 1 selects waveform operation; 0 selects capture, fields reinterpreted.
// - A match acts on output A: none, set, clear, toggle.
// - C match acts on output A: none, set, clear, toggle.
// - External event acts on output A: none, set, clear, toggle.
// - Software trigger acts on output A: none, set, clear, toggle.
// - B match acts on output B: none, set, clear, toggle.
// - C match acts on output B: none, set, clear, toggle.
// - External event acts on output B: none, set, clear, toggle.
// - Software trigger acts on output B: none, set, clear, toggle.
// - Counter value register reads live 16-bit count, resets zero, read-only.
// - Compare A and B writable only in waveform mode; 16 bits, reset zero.
// - Compare C always readable and writable; 16 bits, reset zero.
// - Writing the soft trigger command bit resets counter and starts clock.
// - A match in waveform mode sets a flag held until status is read.
`timescale 1ns/100ps
`include "timer_regs.svh"

module timer_waveform_channel #(
    parameter int ADDR_W = 8,
    parameter int CNT_W = 16
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [2:0] ext_clock_line_in,
    input wire logic wave_b_pin_in,
    output logic wave_out_a_out,
    output logic wave_out_b_out,
    output logic wave_b_oe_out
);
    import timer_pkg::*;

    logic [2:0] ext_meta;
    logic [2:0] ext_sync;
    logic pin_b_meta;
    logic pin_b_sync;
    logic event_prev;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [31:0] channel_mode_waveform;
    logic [CNT_W-1:0] counter_value;
    logic [CNT_W-1:0] compare_a_value;
    logic [CNT_W-1:0] compare_b_value;
    logic [CNT_W-1:0] compare_c_value;
    logic clock_on;
    logic clock_stopped;
    logic count_moved;
    logic flag_overflow;
    logic a_match_flag;
    logic flag_b_match;
    logic flag_c_match;
    logic flag_event;
    logic tick;
    logic do_write;
    logic [31:0] merged;
    logic wave_mode;
    logic b_is_input;
    logic event_level;
    logic event_hit;
    logic a_match;
    logic b_match;
    logic c_match;
    logic overflow;
    logic cmd_clock_enable;
    logic cmd_clock_disable;
    logic soft_trigger_cmd;
    logic trigger;
    logic running;
    logic status_read;
    logic next_out_a;
    logic next_out_b;

    // Applies one set/clear/toggle action to an output level
    function automatic logic apply_action(input logic cur, input logic [1:0] code);
        case (out_action_t'(code))
            act_set: apply_action = 1'b1;
            act_clear: apply_action = 1'b0;
            act_toggle: apply_action = ~cur;
            default: apply_action = cur;
        endcase
    endfunction

    // Byte-lane merge, shared by every writable register
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        lane_merge = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    // Pins come from outside the clock domain
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            ext_meta <= 3'h0;
            ext_sync <= 3'h0;
            pin_b_meta <= 1'b0;
            pin_b_sync <= 1'b0;
        end else if (clk_en_in) begin
            ext_meta <= ext_clock_line_in;
            ext_sync <= ext_meta;
            pin_b_meta <= wave_b_pin_in;
            pin_b_sync <= pin_b_meta;
        end
    end

    count_tick_gen #(
        .DIV_W(`DIV_WIDTH)
    ) u_tick (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .clock_select_in(channel_mode_waveform[`F_CLOCK_SELECT +: 3]),
        .clock_invert_in(channel_mode_waveform[`F_CLOCK_INVERT]),
        .burst_in(channel_mode_waveform[`F_BURST +: 2]),
        .ext_lines_in(ext_sync),
        .tick_out(tick)
    );

    assign wave_mode = channel_mode_waveform[`F_WAVE_MODE];
    assign b_is_input = (event_source_t'(channel_mode_waveform[`F_EVENT_SOURCE +: 2])
                         == src_pin_b);

    always_comb begin
        case (event_source_t'(channel_mode_waveform[`F_EVENT_SOURCE +: 2]))
            src_line_0: event_level = ext_sync[0];
            src_line_1: event_level = ext_sync[1];
            src_line_2: event_level = ext_sync[2];
            default: event_level = pin_b_sync;
        endcase
        case (event_edge_t'(channel_mode_waveform[`F_EVENT_EDGE +: 2]))
            edge_rising: event_hit = event_level & ~event_prev;
            edge_falling: event_hit = ~event_level & event_prev;
            edge_both: event_hit = event_level ^ event_prev;
            default: event_hit = 1'b0;
        endcase
        event_hit = event_hit & wave_mode;
    end

    // Matches only on an increment, so a trigger back to zero never re-fires
    assign a_match = wave_mode & count_moved & (counter_value == compare_a_value);
    assign b_match = wave_mode & count_moved & (counter_value == compare_b_value);
    assign c_match = wave_mode & count_moved & (counter_value == compare_c_value);
    assign overflow = count_moved & (counter_value == '0);

    assign do_write = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
    assign merged = lane_merge(32'h0, w_data, w_strb);
    assign cmd_clock_enable = do_write & (aw_addr == `OFS_CONTROL)
                              & merged[`F_CMD_CLOCK_ENABLE];
    assign cmd_clock_disable = do_write & (aw_addr == `OFS_CONTROL)
                               & merged[`F_CMD_CLOCK_DISABLE];
    assign soft_trigger_cmd = do_write & (aw_addr == `OFS_CONTROL)
                              & merged[`F_CMD_SOFT_TRIGGER];
    assign trigger = soft_trigger_cmd
                     | (event_hit & channel_mode_waveform[`F_EVENT_TRIG_EN])
                     | (c_match & channel_mode_waveform[`F_C_TRIG_EN]);
    assign running = tick & clock_on & ~clock_stopped;
    assign status_read = s_axi_arvalid_in & s_axi_arready_out
                         & (s_axi_araddr_in == `OFS_STATUS);

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            event_prev <= 1'b0;
        end else if (clk_en_in) begin
            event_prev <= event_level;
        end
    end

    // Counter: trigger wins over an increment on the same tick
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            counter_value <= `RST_VALUE16;
            count_moved <= 1'b0;
        end else if (clk_en_in) begin
            count_moved <= running & ~trigger;
            if (trigger) begin
                counter_value <= '0;
            end else if (running) begin
                counter_value <= counter_value + 1'b1;
            end
        end
    end

    // Clock state; a C match stop or disable wins over its own trigger
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            clock_on <= 1'b0;
            clock_stopped <= 1'b0;
        end else if (clk_en_in) begin
            if (cmd_clock_disable
                | (c_match & channel_mode_waveform[`F_DISABLE_ON_C])) begin
                clock_on <= 1'b0;
            end else if (cmd_clock_enable) begin
                clock_on <= 1'b1;
            end
            if (c_match & channel_mode_waveform[`F_STOP_ON_C]) begin
                clock_stopped <= 1'b1;
            end else if (trigger) begin
                clock_stopped <= 1'b0;
            end
        end
    end

    // Later actions override earlier ones: A or B, C, event, then soft trigger
    always_comb begin
        next_out_a = wave_out_a_out;
        if (a_match) begin
            next_out_a = apply_action(next_out_a, channel_mode_waveform[`F_A_ON_A +: 2]);
        end
        if (c_match) begin
            next_out_a = apply_action(next_out_a, channel_mode_waveform[`F_A_ON_C +: 2]);
        end
        if (event_hit) begin
            next_out_a = apply_action(next_out_a,
                                      channel_mode_waveform[`F_A_ON_EVENT +: 2]);
        end
        if (soft_trigger_cmd & wave_mode) begin
            next_out_a = apply_action(next_out_a,
                                      channel_mode_waveform[`F_A_ON_SOFT +: 2]);
        end
        next_out_b = wave_out_b_out;
        if (b_match) begin
            next_out_b = apply_action(next_out_b, channel_mode_waveform[`F_B_ON_B +: 2]);
        end
        if (c_match) begin
            next_out_b = apply_action(next_out_b, channel_mode_waveform[`F_B_ON_C +: 2]);
        end
        if (event_hit) begin
            next_out_b = apply_action(next_out_b,
                                      channel_mode_waveform[`F_B_ON_EVENT +: 2]);
        end
        if (soft_trigger_cmd & wave_mode) begin
            next_out_b = apply_action(next_out_b,
                                      channel_mode_waveform[`F_B_ON_SOFT +: 2]);
        end
        if (b_is_input) begin
            next_out_b = wave_out_b_out;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            wave_out_a_out <= 1'b0;
            wave_out_b_out <= 1'b0;
            wave_b_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            wave_out_a_out <= next_out_a;
            wave_out_b_out <= next_out_b;
            wave_b_oe_out <= wave_mode & ~b_is_input;
        end
    end

    // Sticky flags: a new event in the reading cycle is kept
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            flag_overflow <= 1'b0;
            a_match_flag <= 1'b0;
            flag_b_match <= 1'b0;
            flag_c_match <= 1'b0;
            flag_event <= 1'b0;
        end else if (clk_en_in) begin
            flag_overflow <= (flag_overflow & ~status_read) | overflow;
            a_match_flag <= (a_match_flag & ~status_read) | a_match;
            flag_b_match <= (flag_b_match & ~status_read) | b_match;
            flag_c_match <= (flag_c_match & ~status_read) | c_match;
            flag_event <= (flag_event & ~status_read) | event_hit;
        end
    end

    // Write channels: address and data taken in either order
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= resp_okay;
            aw_addr <= '0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (clk_en_in) begin
            if (s_axi_awvalid_in & s_axi_awready_out) begin
                aw_addr <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in & s_axi_wready_out) begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (do_write) begin
                s_axi_bvalid_out <= 1'b1;
                if (aw_addr == `OFS_CONTROL || aw_addr == `OFS_MODE
                    || aw_addr == `OFS_COUNT || aw_addr == `OFS_COMPARE_A
                    || aw_addr == `OFS_COMPARE_B || aw_addr == `OFS_COMPARE_C
                    || aw_addr == `OFS_STATUS) begin
                    s_axi_bresp_out <= resp_okay;
                end else begin
                    s_axi_bresp_out <= resp_slverr;
                end
            end else if (s_axi_bvalid_out & s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    // Register storage; counter and status writes are accepted and dropped
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            channel_mode_waveform <= `RST_MODE;
            compare_a_value <= `RST_VALUE16;
            compare_b_value <= `RST_VALUE16;
            compare_c_value <= `RST_VALUE16;
        end else if (clk_en_in && do_write) begin
            if (aw_addr == `OFS_MODE) begin
                channel_mode_waveform <= lane_merge(channel_mode_waveform, w_data, w_strb)
                                         & `MODE_WRITE_MASK;
            end else if (aw_addr == `OFS_COMPARE_A && wave_mode) begin
                compare_a_value <= CNT_W'(lane_merge({16'h0, compare_a_value},
                                                     w_data, w_strb));
            end else if (aw_addr == `OFS_COMPARE_B && wave_mode) begin
                compare_b_value <= CNT_W'(lane_merge({16'h0, compare_b_value},
                                                     w_data, w_strb));
            end else if (aw_addr == `OFS_COMPARE_C) begin
                compare_c_value <= CNT_W'(lane_merge({16'h0, compare_c_value},
                                                     w_data, w_strb));
            end
        end
    end

    // Read channel: one read at a time, data held until taken
    always_ff @(posedge core_clk_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= resp_okay;
        end else if (clk_en_in) begin
            if (s_axi_arvalid_in & s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= resp_okay;
                s_axi_rdata_out <= 32'h0;
                if (s_axi_araddr_in == `OFS_MODE) begin
                    s_axi_rdata_out <= channel_mode_waveform;
                end else if (s_axi_araddr_in == `OFS_COUNT) begin
                    s_axi_rdata_out <= {16'h0, counter_value};
                end else if (s_axi_araddr_in == `OFS_COMPARE_A) begin
                    s_axi_rdata_out <= {16'h0, compare_a_value};
                end else if (s_axi_araddr_in == `OFS_COMPARE_B) begin
                    s_axi_rdata_out <= {16'h0, compare_b_value};
                end else if (s_axi_araddr_in == `OFS_COMPARE_C) begin
                    s_axi_rdata_out <= {16'h0, compare_c_value};
                end else if (s_axi_araddr_in == `OFS_STATUS) begin
                    s_axi_rdata_out[`F_ST_OVERFLOW] <= flag_overflow;
                    s_axi_rdata_out[`F_ST_A_MATCH] <= a_match_flag;
                    s_axi_rdata_out[`F_ST_B_MATCH] <= flag_b_match;
                    s_axi_rdata_out[`F_ST_C_MATCH] <= flag_c_match;
                    s_axi_rdata_out[`F_ST_EVENT] <= flag_event;
                    s_axi_rdata_out[`F_ST_CLOCK_ON] <= clock_on;
                    s_axi_rdata_out[`F_ST_MIRROR_A] <= wave_out_a_out;
                    s_axi_rdata_out[`F_ST_MIRROR_B] <= b_is_input ? pin_b_sync
                                                                  : wave_out_b_out;
                end else if (s_axi_araddr_in != `OFS_CONTROL) begin
                    s_axi_rresp_out <= resp_slverr;
                end
            end else if (s_axi_rvalid_out & s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
                s_axi_arready_out <= 1'b1;
            end
        end
    end
endmodule

// >>> sim/timer_channel_monitor.sv
`timescale 1ns/100ps
module timer_channel_monitor #(
    parameter int ADDR_W = 8
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic [ADDR_W-1:0] s_axi_araddr_in,
    input wire logic s_axi_awvalid_in,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_wvalid_in,
    input wire logic s_axi_wready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic s_axi_arvalid_in,
    input wire logic s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic [1:0] s_axi_rresp_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic wave_out_a_out,
    input wire logic wave_out_b_out,
    input wire logic wave_b_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("write answer dropped");
    a_r_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read answer changed");
    a_aw_refused: assert property (s_axi_awvalid_in && s_axi_awready_out |=> !s_axi_awready_out)
        else $error("second write taken");
    a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
        else $error("write answer late");
    a_read_release: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out && s_axi_arready_out)
        else $error("read not released");
    a_unmapped_err: assert property (s_axi_arvalid_in && s_axi_arready_out && s_axi_araddr_in == 8'h08 |=> s_axi_rresp_out == 2'b10 && s_axi_rdata_out == 32'h0)
        else $error("unmapped read not refused");
    a_reset_idle: assert property (disable iff (1'b0) sys_rst_in |=> !s_axi_bvalid_out && !s_axi_rvalid_out && !wave_out_a_out && !wave_b_oe_out)
        else $error("reset state wrong");
    a_b_input_quiet: assert property (!wave_b_oe_out ##1 !wave_b_oe_out |-> $stable(wave_out_b_out))
        else $error("waveform on input pin");
    c_read: cover property (s_axi_rvalid_out && s_axi_rready_in);
    c_write: cover property (s_axi_bvalid_out && s_axi_bready_in);
    c_wave_a: cover property ($rose(wave_out_a_out));
endmodule

bind timer_waveform_channel timer_channel_monitor #(.ADDR_W(ADDR_W)) mon (.*);

// >>> sim/timer_pins_model.sv
`timescale 1ns/100ps
module timer_pins_model (
    input wire logic [3:0] stim_in,
    input wire logic b_level_in,
    input wire logic b_oe_in,
    output logic [2:0] ext_lines_out,
    output logic pin_b_out
);
    // Lines are plain levels, so the bench chooses every edge
    assign ext_lines_out = stim_in[2:0];
    // Pin B follows the device only while it owns it
    assign pin_b_out = b_oe_in ? b_level_in : stim_in[3];
endmodule

// >>> sim/timer_waveform_channel_test.sv
`timescale 1ns/100ps
module timer_waveform_channel_test;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] r;} row_t;
    logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
    logic rready, oe, wave_a, wave_b, pin_b, last;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp, r;
    logic [2:0] lines;
    logic [3:0] stim;
    int n_checks, miscompares, cycles, t;
    logic [7:0] rst_addr[5] = '{8'h04, 8'h10, 8'h14, 8'h18, 8'h1c};
    row_t rows[6] = '{'{8'h04, 32'hffff_ffff, 32'hffff_dfff, 2'b00},
        '{8'h14, 32'hffff_1234, 32'h1234, 2'b00}, '{8'h1c, 32'h55, 32'h55, 2'b00},
        '{8'h04, 32'h0, 32'h0, 2'b00}, '{8'h18, 32'h9999, 32'h0, 2'b00},
        '{8'h08, 32'h1, 32'h0, 2'b10}};
    timer_waveform_channel uut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .ext_clock_line_in(lines),
        .wave_b_pin_in(pin_b), .wave_out_a_out(wave_a), .wave_out_b_out(wave_b),
        .wave_b_oe_out(oe));
    timer_pins_model pins (.stim_in(stim), .b_level_in(wave_b), .b_oe_in(oe),
        .ext_lines_out(lines), .pin_b_out(pin_b));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] s);
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            s = bresp;
        end while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic bus_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        {v, s} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Whole run is under 2000 cycles; the ceiling leaves ample slack
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            test_done;
        end
    end
    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, stim} = {1'b1, 57'h0};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rst_addr[i]) begin
            bus_rd(rst_addr[i], d, r);
            chk("reset value", 32'h0, d);
        end
        foreach (rows[i]) begin
            bus_wr(rows[i].a, rows[i].w, r);
            chk("write resp", rows[i].r, r);
            bus_rd(rows[i].a, d, r);
            chk("read data", rows[i].e, d);
        end
        $display("register tests done");
        bus_wr(8'h1c, 32'h4, r);
        bus_wr(8'h04, 32'h000c_c000, r);
        bus_wr(8'h00, 32'h1, r);
        {t, last} = {32'h0, wave_a};
        repeat (100) begin
            @(posedge clk);
            t += (wave_a !== last);
            last = wave_a;
        end
        chk("a toggles", 1, t > 4);
        bus_rd(8'h10, d, r);
        chk("count range", 1, d <= 4);
        bus_wr(8'h04, 32'h0040_8040, r);
        bus_wr(8'h00, 32'h4, r);
        bus_rd(8'h10, d, r);
        chk("count after trigger", 1, d < 4);
        repeat (30) @(posedge clk);
        bus_rd(8'h10, d, r);
        chk("stopped count", 32'h4, d);
        chk("soft set a", 1, wave_a);
        $display("counter tests done");
        bus_wr(8'h04, 32'h0020_9100, r);
        chk("pin b released", 0, oe);
        stim <= 4'h8;
        repeat (10) @(posedge clk);
        chk("event clears a", 0, wave_a);
        bus_wr(8'h04, 32'h0020_9500, r);
        @(posedge clk);
        chk("pin b driven", 1, oe);
        $display("event tests done");
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bus_rd(8'h04, d, r);
        chk("reset mode", 32'h0, d);
        test_done;
    end
endmodule
